/* File: logic/node_cmd_pkg.sv */
// constants and types of the node command and status logic
package node_cmd_pkg;
  localparam int REG_AW = 4;
  localparam logic [3:0] OFS_COMMAND = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_CONFIG = 4'hc;
  localparam int CFG_WIDE16 = 0;
  localparam int CFG_IO_MAP = 1;
  localparam int CFG_ZERO_WAIT = 2;
  localparam int CFG_LONG_PKT = 3;
  localparam int CFG_CHAIN = 6;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int MASK_TX_AVAIL = 0;
  localparam int MASK_RX_INHIBIT = 7;
  localparam int PAGE_W = 3;
  localparam int BUF_AW = 11;
  localparam int LEN_W = 10;
  localparam logic [1:0] OFS_SOURCE_ID = 2'h0;
  localparam logic [1:0] OFS_DEST_ID = 2'h1;
  localparam logic [1:0] OFS_COUNT = 2'h2;
  localparam logic [1:0] OFS_LONG_COUNT = 2'h3;
  localparam logic [LEN_W-1:0] SHORT_SPAN = 10'h100;
  localparam logic [LEN_W-1:0] LONG_SPAN = 10'h200;
  localparam int CLOCK_MHZ = 200;
  localparam int INT_GAP_NS = 200;
  localparam int INT_GAP_CYCLES = (INT_GAP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int GAP_W = 6;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_DISABLE_TX = 3'h1,
    OP_DISABLE_RX = 3'h2,
    OP_ENABLE_TX = 3'h3,
    OP_ENABLE_RX = 3'h4,
    OP_CLEAR_TX_INT = 3'h5,
    OP_CLEAR_RX_INT = 3'h6
  } opcode_e;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} tx_state_e;
  typedef struct packed {
    logic rxInhibit;
    logic [2:0] spare;
    logic rxTrans;
    logic txTrans;
    logic txAck;
    logic txAvail;
  } status_s;
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic good;
    logic [7:0] data;
  } rx_byte_s;
  typedef struct packed {
    logic we;
    logic [BUF_AW-1:0] addr;
    logic [7:0] data;
  } buf_write_s;
endpackage

/* File: logic/pending_queue.sv */
// two-level first-in first-out queue of pending page commands
`timescale 1ns/1ps
`default_nettype none
module pending_queue #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  // drain side
  input wire logic pop,
  output logic headValid,
  output logic [WIDTH-1:0] head,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] entries [DEPTH];
  logic [CW-1:0] fill;
  wire doPop = pop && (fill != '0);
  wire doPush = push && (fill != CW'(DEPTH) || doPop);
  wire [CW-1:0] writeIdx = doPop ? fill - 1'b1 : fill;
  wire [CW-1:0] next_fill = fill + CW'(doPush) - CW'(doPop);

  if (DEPTH < 1 || WIDTH < 1) begin : g_bad
    $error("pending_queue needs positive depth and width");
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire [WIDTH-1:0] upper = (i + 1 < DEPTH) ? entries[(i + 1) % DEPTH] : '0;
    wire [WIDTH-1:0] shifted = doPop ? upper : entries[i];
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        entries[i] <= '0;
      end else begin
        entries[i] <= (doPush && writeIdx == CW'(i)) ? pushData : shifted;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fill <= '0;
    end else begin
      fill <= next_fill;
    end
  end

  assign headValid = fill != '0;
  assign head = entries[0];
  assign count = fill;
endmodule
`default_nettype wire

/* File: logic/token_node_cmd.sv */
// command interpreter and chained status of the token node controller
//
// Notes on behaviour
// [R1] a correctly stored packet sets the receiver inhibited flag
// [R2] receiver inhibited and its mask bit raise the interrupt, else software polls
// [R3] enable receive command clears receiver inhibited and selects a page
// [R4] with long packets enabled, zero at location 2 marks a long packet
// [R5] source id at 0, destination at 1, short count 256 minus length at 2
// [R6] long packet holds zero at 2 and 512 minus length at 3
// [R7] received bytes land in the page in the sender's order
// [R8] reset gives 8-bit width, memory mapping, no chaining, no zero wait
// [R9] chaining only while configuration bit 6 is set
// [R10] chaining holds two transmit and two receive commands in any order
// [R11] chaining holds two transmit and two receive completions with status
// [R12] in chaining the masks gate only the transition flags
// [R13] live available and inhibited flags stay visible beside transitions
// [R14] first enable transmit clears available and acknowledged flags
// [R15] a second enable transmit is stored with its page
// [R16] completion sets transmit transition, interrupts, shows acknowledge
// [R17] only clear transmit interrupt drops the transition and interrupt
// [R18] second completion is withheld until the first is cleared
// [R19] acknowledge is buffered with its transition and never interrupts
// [R20] stored transmit starts on the next token after the first completes
// [R21] interrupt stays low at least 200 ns between successive assertions; kept only in chaining, before the next transition of the cleared direction
// [R22] each disable transmitter cancels the oldest pending transmission
// [R23] only clear receive interrupt drops the receive transition flag
// [R24] acknowledged completion sets acknowledge and available; else acknowledge stays low
// [R25] pending commands sit in depth-two queues, served in issue order
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module token_node_cmd (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [node_cmd_pkg::REG_AW-1:0] address,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  // network engine
  input wire logic tokenArrive,
  input wire logic txDone,
  input wire logic txAcked,
  input wire node_cmd_pkg::rx_byte_s rxIn,
  output logic txStart,
  output logic [node_cmd_pkg::PAGE_W-1:0] txPage,
  output logic txCancel,
  output logic rxArmed,
  output logic [node_cmd_pkg::PAGE_W-1:0] rxPage,
  output logic rxCancel,
  // packet buffer
  output node_cmd_pkg::buf_write_s bufWrite,
  output logic [node_cmd_pkg::LEN_W-1:0] rxLength,
  // host side
  output logic irq,
  output logic cfgWide16,
  output logic cfgIoMapped,
  output logic cfgZeroWait
);
  import node_cmd_pkg::*;

  localparam int CW = 2;
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(INT_GAP_CYCLES);

  logic [7:0] config_;
  logic [7:0] mask;
  logic txAvail, txAck, rxInhibit;
  tx_state_e txState;
  logic rxActive, isLong;
  logic [8:0] rxIdx;
  logic [7:0] countByte;
  logic [PAGE_W-1:0] rxBusyPage;
  logic [1:0] trans, transFlag, held, heldFlag;
  logic [GAP_W-1:0] gap [2];
  logic [CW-1:0] txCount, rxCount;
  logic txQValid, rxQValid;
  logic [PAGE_W-1:0] txHead, rxHead;

  // command decode
  wire cmdWrite = wrStrobe && address == OFS_COMMAND;
  wire [2:0] op = cmdWrite ? wrData[2:0] : OP_NONE;
  wire [PAGE_W-1:0] cmdPage = wrData[5:3];
  wire chain = config_[CFG_CHAIN]; // [R9]
  wire longEn = config_[CFG_LONG_PKT];
  wire enTx = op == OP_ENABLE_TX;
  wire enRx = op == OP_ENABLE_RX;
  wire txPush = enTx && (chain || !txQValid); // [R10] [R15]
  wire rxPush = enRx && (chain || !rxQValid); // [R10]
  wire txIdle = txState == TX_IDLE;
  wire txEvent = txDone && txState == TX_BUSY;
  wire disTx = op == OP_DISABLE_TX && txQValid; // [R22]
  wire disRx = op == OP_DISABLE_RX && rxQValid && !rxActive;
  wire txPop = txEvent || disTx;
  wire rxEnd = rxIn.valid && rxIn.last && rxActive;
  wire rxEvent = rxEnd && rxIn.good;
  wire rxPop = rxEvent || disRx;
  wire txLaunch = txIdle && tokenArrive && txQValid && !disTx; // [R20]
  wire [1:0] event_ = chain ? {rxEvent, txEvent} : 2'b00; // [R12]
  wire [1:0] eventFlag = {isLong, txAcked}; // [R19]
  wire [1:0] clearCmd = {op == OP_CLEAR_RX_INT, op == OP_CLEAR_TX_INT}; // [R17] [R23]

  // depth-two command queues
  pending_queue #(.WIDTH(PAGE_W), .DEPTH(2)) u_txQueue ( // [R25]
    .clock(clock),
    .reset_n(reset_n),
    .push(txPush),
    .pushData(cmdPage),
    .pop(txPop),
    .headValid(txQValid),
    .head(txHead),
    .count(txCount)
  );
  pending_queue #(.WIDTH(PAGE_W), .DEPTH(2)) u_rxQueue ( // [R25]
    .clock(clock),
    .reset_n(reset_n),
    .push(rxPush),
    .pushData(cmdPage),
    .pop(rxPop),
    .headValid(rxQValid),
    .head(rxHead),
    .count(rxCount)
  );

  // double-buffered transition status per direction
  for (genvar k = 0; k < 2; k++) begin : g_trans
    wire promote = !trans[k] && held[k] && gap[k] == '0; // [R18] [R21]
    wire direct = event_[k] && !trans[k] && !held[k] && gap[k] == '0;
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        trans[k] <= 1'b0;
        transFlag[k] <= 1'b0;
        held[k] <= 1'b0;
        heldFlag[k] <= 1'b0;
        gap[k] <= '0;
      end else begin
        if (clearCmd[k] && trans[k]) begin
          trans[k] <= 1'b0; // [R17] [R23]
          gap[k] <= GAP_LOAD; // [R21]
        end else if (gap[k] != '0) begin
          gap[k] <= gap[k] - 1'b1;
        end
        if (direct) begin
          trans[k] <= 1'b1; // [R16] [R11]
          transFlag[k] <= eventFlag[k]; // [R19]
        end else if (promote) begin
          trans[k] <= 1'b1; // [R18]
          transFlag[k] <= heldFlag[k];
          held[k] <= 1'b0;
        end
        if (event_[k] && !direct) begin
          held[k] <= 1'b1; // [R11] [R18]
          heldFlag[k] <= eventFlag[k];
        end
      end
    end
  end

  // live transmitter flags and transmit sequencing
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      txAvail <= 1'b1;
      txAck <= 1'b0;
      txState <= TX_IDLE;
      txStart <= 1'b0;
      txCancel <= 1'b0;
      txPage <= '0;
    end else begin
      txStart <= txLaunch;
      txCancel <= disTx; // [R22]
      if (txLaunch) begin
        txPage <= txHead;
      end
      if (txPush && txCount == '0) begin
        txAvail <= 1'b0; // [R14]
        txAck <= 1'b0; // [R14]
      end else if (txPop && txCount == 2'd1) begin
        txAvail <= 1'b1; // [R24] [R13]
      end
      if (txEvent && txAcked) begin
        txAck <= 1'b1; // [R24]
      end
      case (txState)
        TX_IDLE: begin
          if (txLaunch) begin
            txState <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (txDone || disTx) begin
            txState <= TX_IDLE;
          end
        end
        default: begin
          txState <= TX_IDLE;
        end
      endcase
    end
  end

  // receive into the selected page
  wire [8:0] pageSpan = longEn ? 9'h1ff : 9'h0ff;
  wire inPage = rxIdx <= pageSpan;
  wire [BUF_AW-1:0] pageBase = longEn ? {rxBusyPage[1:0], 9'h000} : {rxBusyPage, 8'h00};
  wire [BUF_AW-1:0] byteAddr = pageBase | {2'b00, rxIdx};
  wire rxTake = rxIn.valid && (rxActive || (rxIn.first && rxQValid));
  wire [8:0] idxNow = (rxIn.first && !rxActive) ? 9'h000 : rxIdx;
  wire longMark = longEn && idxNow == {7'h00, OFS_COUNT} && rxIn.data == 8'h00; // [R4] [R6]
  wire [LEN_W-1:0] next_rxLength = isLong ? LONG_SPAN - {2'b00, countByte} // [R6]
                                          : SHORT_SPAN - {2'b00, countByte}; // [R5]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rxInhibit <= 1'b1;
      rxActive <= 1'b0;
      rxIdx <= '0;
      isLong <= 1'b0;
      countByte <= '0;
      rxBusyPage <= '0;
      bufWrite <= '0;
      rxLength <= '0;
      rxArmed <= 1'b0;
      rxPage <= '0;
      rxCancel <= 1'b0;
    end else begin
      rxArmed <= rxPush || (rxQValid && !rxPop) || (rxCount == 2'd2); // [R3]
      rxPage <= rxHead;
      rxCancel <= disRx;
      if (rxPush && rxCount == '0) begin
        rxInhibit <= 1'b0; // [R3]
      end else if (rxPop && rxCount == 2'd1 && rxEvent) begin
        rxInhibit <= 1'b1; // [R1] [R13]
      end
      bufWrite.we <= 1'b0;
      if (rxIn.valid && rxIn.first && !rxActive && rxQValid) begin
        rxActive <= 1'b1;
        rxBusyPage <= rxHead;
        isLong <= 1'b0;
      end
      if (rxTake) begin
        bufWrite.we <= (rxActive ? inPage : 1'b1);
        bufWrite.addr <= (rxActive ? byteAddr
                                   : (longEn ? {rxHead[1:0], 9'h000} : {rxHead, 8'h00})); // [R7]
        bufWrite.data <= rxIn.data; // [R7] [R5]
        rxIdx <= idxNow + 1'b1;
        if (longMark) begin
          isLong <= 1'b1; // [R4]
        end
        if (idxNow == {7'h00, OFS_COUNT} && !longMark) begin
          countByte <= rxIn.data; // [R5]
        end
        if (idxNow == {7'h00, OFS_LONG_COUNT} && isLong) begin
          countByte <= rxIn.data; // [R6]
        end
      end
      if (rxEnd) begin
        rxActive <= 1'b0;
        rxIdx <= '0;
      end
      if (rxEvent) begin
        rxLength <= next_rxLength;
      end
    end
  end

  // registers
  wire next_irq = chain ? (trans[0] && mask[MASK_TX_AVAIL]) || (trans[1] && mask[MASK_RX_INHIBIT]) // [R12]
                        : (txAvail && mask[MASK_TX_AVAIL]) || (rxInhibit && mask[MASK_RX_INHIBIT]); // [R2]
  status_s status;
  assign status = '{rxInhibit: rxInhibit, spare: 3'h0, rxTrans: trans[1], txTrans: trans[0],
                    txAck: chain ? transFlag[0] : txAck, txAvail: txAvail}; // [R13] [R19]
  wire [7:0] readMux = (address == OFS_STATUS) ? status
                     : (address == OFS_MASK) ? mask
                     : (address == OFS_CONFIG) ? config_ : 8'h00;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      config_ <= CONFIG_RESET; // [R8]
      mask <= MASK_RESET;
      rdData <= '0;
      irq <= 1'b0;
      cfgWide16 <= 1'b0;
      cfgIoMapped <= 1'b0;
      cfgZeroWait <= 1'b0;
    end else begin
      if (wrStrobe && address == OFS_CONFIG) begin
        config_ <= wrData;
      end
      if (wrStrobe && address == OFS_MASK) begin
        mask <= wrData;
      end
      rdData <= rdStrobe ? readMux : 8'h00;
      irq <= next_irq;
      cfgWide16 <= config_[CFG_WIDE16]; // [R8]
      cfgIoMapped <= config_[CFG_IO_MAP];
      cfgZeroWait <= config_[CFG_ZERO_WAIT];
    end
  end

  // checks
  logic [7:0] irqLow;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irqLow <= 8'hff;
    end else if ((clearCmd & trans) != 2'b00) begin
      irqLow <= '0;
    end else if (irqLow != 8'hff) begin
      irqLow <= irqLow + 1'b1;
    end
  end

  sequence s_second_done;
    txEvent && txCount == 2'd2;
  endsequence
  sequence s_token_idle;
    tokenArrive && txIdle && txQValid && !disTx;
  endsequence

  property p_rx_done_inhibits;
    @(posedge clock) disable iff (!reset_n) (rxEvent && rxCount == 2'd1) |=> rxInhibit;
  endproperty
  a_rx_done_inhibits: assert property (p_rx_done_inhibits) else $error("inhibit not set"); // [R1]
  property p_irq_nochain;
    @(posedge clock) disable iff (!reset_n)
      (!chain && rxInhibit && mask[MASK_RX_INHIBIT] && !wrStrobe) |=> irq;
  endproperty
  a_irq_nochain: assert property (p_irq_nochain) else $error("no interrupt on inhibit"); // [R2]
  property p_enrx_clears;
    @(posedge clock) disable iff (!reset_n) (rxPush && rxCount == '0) |=> !rxInhibit && rxArmed;
  endproperty
  a_enrx_clears: assert property (p_enrx_clears) else $error("inhibit not cleared"); // [R3]
  property p_no_chain_single;
    @(posedge clock) disable iff (!reset_n)
      (enTx && !chain && txQValid) |=> txCount <= $past(txCount);
  endproperty
  a_no_chain_single: assert property (p_no_chain_single) else $error("second tx taken"); // [R9]
  property p_first_tx_clears;
    @(posedge clock) disable iff (!reset_n) (txPush && txCount == '0) |=> !txAvail && !txAck;
  endproperty
  a_first_tx_clears: assert property (p_first_tx_clears) else $error("tx flags kept"); // [R14]
  property p_done_recorded;
    @(posedge clock) disable iff (!reset_n) (txEvent && chain) |=> trans[0] || held[0];
  endproperty
  a_done_recorded: assert property (p_done_recorded) else $error("completion lost"); // [R16]
  property p_tx_trans_holds;
    @(posedge clock) disable iff (!reset_n)
      (trans[0] && !clearCmd[0]) |=> trans[0] && $stable(transFlag[0]);
  endproperty
  a_tx_trans_holds: assert property (p_tx_trans_holds) else $error("transition dropped"); // [R17]
  property p_auto_second;
    @(posedge clock) disable iff (!reset_n) s_second_done ##[1:200] s_token_idle |=> txStart;
  endproperty
  a_auto_second: assert property (p_auto_second) else $error("stored tx not started"); // [R20]
  property p_irq_gap;
    @(posedge clock) disable iff (!reset_n) ($rose(irq) && chain) |-> irqLow >= INT_GAP_CYCLES;
  endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("interrupt low time short"); // [R21]
  property p_disable_oldest;
    @(posedge clock) disable iff (!reset_n)
      disTx |=> txCount == $past(txCount) - 2'd1 ##0 txCancel;
  endproperty
  a_disable_oldest: assert property (p_disable_oldest) else $error("cancel failed"); // [R22]
endmodule
`default_nettype wire

/* File: verif/engine_model.sv */
// behavioural network engine facing the node command logic
`timescale 1ns/1ps
`default_nettype none
module engine_model (
  // clock
  input wire logic clock,
  // toward the controller
  output logic tokenArrive,
  output logic txDone,
  output logic txAcked,
  output node_cmd_pkg::rx_byte_s rxIn
);
  import node_cmd_pkg::*;
  logic sending;
  initial begin
    tokenArrive = 1'b0;
    txDone = 1'b0;
    txAcked = 1'b0;
    rxIn = '0;
    sending = 1'b0;
  end
  // idle byte lane keeps changing so a stale byte never looks held
  always @(posedge clock) begin
    if (!sending) rxIn.data <= ~rxIn.data;
  end
  task automatic token();
    @(posedge clock);
    tokenArrive <= 1'b1;
    @(posedge clock);
    tokenArrive <= 1'b0;
  endtask
  task automatic done(input logic ack);
    @(posedge clock);
    txDone <= 1'b1;
    txAcked <= ack;
    @(posedge clock);
    txDone <= 1'b0;
    txAcked <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b[$]);
    sending = 1'b1;
    for (int i = 0; i < b.size(); i++) begin
      @(posedge clock);
      rxIn <= '{valid: 1'b1, first: (i == 0), last: (i == b.size() - 1), good: 1'b1, data: b[i]};
    end
    @(posedge clock);
    rxIn.valid <= 1'b0;
    rxIn.first <= 1'b0;
    rxIn.last <= 1'b0;
    rxIn.good <= 1'b0;
    sending = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench of the node command logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import node_cmd_pkg::*;
  logic clock, reset_n, wrStrobe, rdStrobe;
  logic [REG_AW-1:0] address;
  logic [7:0] wrData, rdData, d;
  logic tokenArrive, txDone, txAcked, txStart, txCancel, rxArmed, rxCancel, irq;
  logic [PAGE_W-1:0] txPage, rxPage;
  logic cfgWide16, cfgIoMapped, cfgZeroWait;
  rx_byte_s rxIn;
  buf_write_s bufWrite;
  logic [LEN_W-1:0] rxLength;
  int n_mismatch, compares, nCancel, nRxCancel;
  logic [PAGE_W-1:0] startLog[$];
  logic [7:0] mem[int];
  logic [7:0] pkt[$];

  token_node_cmd uut (.clock(clock), .reset_n(reset_n), .address(address), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .tokenArrive(tokenArrive),
    .txDone(txDone), .txAcked(txAcked), .rxIn(rxIn), .txStart(txStart), .txPage(txPage),
    .txCancel(txCancel), .rxArmed(rxArmed), .rxPage(rxPage), .rxCancel(rxCancel),
    .bufWrite(bufWrite), .rxLength(rxLength), .irq(irq), .cfgWide16(cfgWide16),
    .cfgIoMapped(cfgIoMapped), .cfgZeroWait(cfgZeroWait));
  engine_model eng (.clock(clock), .tokenArrive(tokenArrive), .txDone(txDone),
    .txAcked(txAcked), .rxIn(rxIn));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (txStart === 1'b1) startLog.push_back(txPage);
    if (txCancel === 1'b1) nCancel++;
    if (rxCancel === 1'b1) nRxCancel++;
    if (bufWrite.we === 1'b1) mem[bufWrite.addr] = bufWrite.data;
  end

  task print_verdict;
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [REG_AW-1:0] a, input logic [7:0] v);
    @(posedge clock);
    address <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask
  task rd(input logic [REG_AW-1:0] a);
    @(posedge clock);
    address <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  task st(input logic [7:0] m, input logic [7:0] v);
    rd(OFS_STATUS);
    check({8'h00, d & m}, {8'h00, v});
  endtask
  task cmd(input opcode_e op, input logic [2:0] pg);
    wr(OFS_COMMAND, {2'h0, pg, op});
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task gap;
    int i;
    int lows;
    #1;
    i = 0;
    lows = 0;
    while (irq === 1'b1 && i < 8) begin
      @(posedge clock);
      #1 i++;
    end
    while (irq !== 1'b1 && lows < 200) begin
      @(posedge clock);
      #1 lows++;
    end
    check({15'h0, lows >= INT_GAP_CYCLES && lows < 200}, 16'h1);
  endtask
  task mem_chk(input int base);
    for (int i = 0; i < pkt.size(); i++) check({8'h00, mem[base + i]}, {8'h00, pkt[i]});
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    print_verdict;
  end

  initial begin
    reset_n = 1'b0;
    address = '0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    n_mismatch = 0;
    compares = 0;
    nCancel = 0;
    nRxCancel = 0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    st(8'hff, 8'h81);
    rd(OFS_CONFIG); check(d, CONFIG_RESET);
    rd(OFS_MASK); check(d, MASK_RESET);
    check({cfgWide16, cfgIoMapped, cfgZeroWait}, 3'h0);
    wr(OFS_CONFIG, 8'h07); tick(2); check({cfgWide16, cfgIoMapped, cfgZeroWait}, 3'h7);
    rd(4'h2); check(d, 8'h00);
    wr(OFS_CONFIG, 8'h00);
    // plain transmit, one pending only
    wr(OFS_MASK, 8'h01); tick(2); check(irq, 1'b1);
    cmd(OP_ENABLE_TX, 3'h5); cmd(OP_ENABLE_TX, 3'h6);
    st(8'h03, 8'h00);
    eng.token(); eng.done(1'b1); st(8'h03, 8'h03);
    check(startLog.pop_front(), 3'h5);
    eng.token(); tick(3); check(startLog.size(), 0);
    cmd(OP_ENABLE_TX, 3'h6); eng.token(); eng.done(1'b0); st(8'h03, 8'h01);
    check(startLog.pop_front(), 3'h6);
    // cancelling pending transmissions
    cmd(OP_ENABLE_TX, 3'h1); cmd(OP_DISABLE_TX, 3'h0); st(8'h01, 8'h01);
    wr(OFS_CONFIG, 8'h40);
    cmd(OP_ENABLE_TX, 3'h1); cmd(OP_ENABLE_TX, 3'h2); cmd(OP_DISABLE_TX, 3'h0);
    st(8'h01, 8'h00);
    cmd(OP_DISABLE_TX, 3'h0); st(8'h01, 8'h01);
    eng.token(); tick(3); check(nCancel, 3);
    check(startLog.size(), 0);
    // chained transmit
    cmd(OP_ENABLE_TX, 3'h1); cmd(OP_ENABLE_TX, 3'h2); cmd(OP_ENABLE_TX, 3'h3);
    st(8'h07, 8'h00);
    eng.token(); eng.done(1'b1); tick(2); st(8'h07, 8'h06);
    check(irq, 1'b1);
    check(startLog.pop_front(), 3'h1);
    eng.token(); eng.done(1'b0); tick(2); st(8'h07, 8'h07);
    check(startLog.pop_front(), 3'h2);
    cmd(OP_CLEAR_TX_INT, 3'h0); gap(); st(8'h07, 8'h05);
    eng.token(); tick(3); check(startLog.size(), 0);
    cmd(OP_CLEAR_TX_INT, 3'h0); tick(3); check(irq, 1'b0);
    st(8'h05, 8'h01);
    // plain receive, short then long
    wr(OFS_CONFIG, 8'h00); wr(OFS_MASK, 8'h80); tick(2); check(irq, 1'b1);
    cmd(OP_ENABLE_RX, 3'h2); tick(2); st(8'h80, 8'h00);
    check(irq, 1'b0);
    check({rxArmed, rxPage}, 4'ha);
    pkt = '{8'h11, 8'h22, 8'hfc, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
    eng.send(pkt); tick(3); st(8'h80, 8'h80);
    check(rxLength, SHORT_SPAN - 10'h0fc);
    mem_chk(2 << 8);
    check(irq, 1'b1);
    wr(OFS_CONFIG, 8'h08); cmd(OP_ENABLE_RX, 3'h5);
    pkt = '{8'h11, 8'h22, 8'h00, 8'hfe, 8'hb1, 8'hb2};
    eng.send(pkt); tick(3); check(rxLength, LONG_SPAN - 10'h0fe);
    mem_chk(1 << 9);
    // chained receive
    wr(OFS_CONFIG, 8'h40); cmd(OP_ENABLE_RX, 3'h3); cmd(OP_ENABLE_RX, 3'h4);
    pkt = '{8'h33, 8'h44, 8'hfe, 8'hc1, 8'hc2};
    eng.send(pkt); tick(3); st(8'h88, 8'h08);
    check(irq, 1'b1);
    eng.send(pkt); tick(3); st(8'h88, 8'h88);
    mem_chk(4 << 8);
    cmd(OP_CLEAR_RX_INT, 3'h0); gap(); st(8'h08, 8'h08);
    cmd(OP_CLEAR_RX_INT, 3'h0); tick(3); check(irq, 1'b0);
    st(8'h88, 8'h80);
    cmd(OP_ENABLE_RX, 3'h1); cmd(OP_DISABLE_RX, 3'h0); tick(2);
    check({rxArmed, 8'(nRxCancel)}, 9'h001);
    print_verdict;
  end
endmodule
`default_nettype wire
